// File: rtl/pcs_pkg.sv
package pcs_pkg;

    // Management register addresses.
    localparam logic [4:0] REG_CONFIG_ADDR = 5'h10;
    localparam logic [4:0] REG_STATUS2_ADDR = 5'h11;

    // Configuration field positions.
    localparam int CFG_FORCE_LINK_BIT = 14;
    localparam int CFG_TX_DISABLE_BIT = 13;
    localparam int CFG_SCR_BYPASS_BIT = 12;
    localparam int CFG_JABBER_OFF_BIT = 10;
    localparam int CFG_HEARTBEAT_BIT = 9;
    localparam int CFG_LOOPBACK_OFF_BIT = 8;
    localparam int CFG_CRS_EXTEND_BIT = 7;
    localparam int CFG_SLEEP_EN_BIT = 6;
    localparam int CFG_PREAMBLE_BIT = 5;
    localparam int CFG_SLEEP_TMR_HI = 4;
    localparam int CFG_SLEEP_TMR_LO = 3;
    localparam int CFG_FEFI_EN_BIT = 2;
    localparam int CFG_ALT_NP_BIT = 1;
    localparam int CFG_FIBER_BIT = 0;

    // Reset value without the strap bits; bit 15 never stores.
    localparam logic [15:0] CFG_RESET_VAL = 16'h0084;
    localparam logic [15:0] CFG_WR_MASK = 16'h7FFF;

    // Sleep timeouts.
    localparam int CLK_HZ = 10_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int SLEEP_T0_MS = 3040;
    localparam int SLEEP_T1_MS = 2000;
    localparam int SLEEP_T2_MS = 1040;
    localparam int SLEEP_CNT_W = 25;
    localparam logic [SLEEP_CNT_W-1:0] SLEEP_CYC0 = SLEEP_CNT_W'(SLEEP_T0_MS * CYC_PER_MS);
    localparam logic [SLEEP_CNT_W-1:0] SLEEP_CYC1 = SLEEP_CNT_W'(SLEEP_T1_MS * CYC_PER_MS);
    localparam logic [SLEEP_CNT_W-1:0] SLEEP_CYC2 = SLEEP_CNT_W'(SLEEP_T2_MS * CYC_PER_MS);

    // Management frame layout.
    localparam logic [5:0] MDIO_PRE_LEN = 6'h20;
    localparam logic [5:0] MDIO_HDR_LAST = 6'h0C;
    localparam logic [5:0] MDIO_DATA_LAST = 6'h0F;
    localparam logic [5:0] MDIO_RD_END = 6'h10;
    localparam logic [1:0] MDIO_OP_READ = 2'h2;
    localparam logic [1:0] MDIO_OP_WRITE = 2'h1;

    typedef enum logic [2:0] {
        MS_PRE = 3'b000,
        MS_HDR = 3'b001,
        MS_TA = 3'b010,
        MS_RDATA = 3'b011,
        MS_WDATA = 3'b100
    } pcs_mdio_st_t;

endpackage

// File: rtl/pcs_mdio_slave.sv
`timescale 1ns/100ps
module pcs_mdio_slave import pcs_pkg::*; #(
    parameter logic [4:0] P_PHY_ADDR = 5'h00
) (
    input wire logic i_mclk, // System clock.
    input wire logic i_srst, // Synchronous reset.
    input wire logic i_mdc, // Management clock pin.
    input wire logic i_mdio, // Management data pin in.
    output logic o_mdio, // Management data out.
    output logic o_mdio_oe, // Drive enable of data pin.
    output logic [4:0] o_reg_addr, // Addressed register.
    input wire logic [15:0] i_rd_data, // Read value of o_reg_addr.
    output logic o_wr_pulse, // One-cycle write strobe.
    output logic [15:0] o_wr_data // Write data.
);
    logic mdc_s1_q, mdc_s2_q, mdc_s3_q;
    logic dio_s1_q, dio_s2_q;
    logic rise, is_read_q;
    logic [5:0] cnt_q;
    logic [12:0] hdr_q;
    logic [15:0] sh_q;
    logic [12:0] hdr_d;
    pcs_mdio_st_t st_q;

    always_ff @(posedge i_mclk) begin
        mdc_s1_q <= i_mdc;
        mdc_s2_q <= mdc_s1_q;
        mdc_s3_q <= mdc_s2_q;
        dio_s1_q <= i_mdio;
        dio_s2_q <= dio_s1_q;
    end

    assign rise = mdc_s2_q & ~mdc_s3_q;
    assign hdr_d = {hdr_q[11:0], dio_s2_q};

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            st_q <= MS_PRE;
            cnt_q <= 6'h00;
            hdr_q <= 13'h0000;
            sh_q <= 16'h0000;
            is_read_q <= 1'b0;
            o_reg_addr <= 5'h00;
            o_mdio <= 1'b0;
            o_mdio_oe <= 1'b0;
            o_wr_pulse <= 1'b0;
            o_wr_data <= 16'h0000;
        end else begin
            o_wr_pulse <= 1'b0;
            if (rise) begin
                case (st_q)
                    MS_PRE: begin
                        if (dio_s2_q) begin
                            if (cnt_q != MDIO_PRE_LEN) cnt_q <= cnt_q + 6'h01;
                        end else if (cnt_q == MDIO_PRE_LEN) begin
                            st_q <= MS_HDR;
                            cnt_q <= 6'h00;
                        end else begin
                            cnt_q <= 6'h00;
                        end
                    end
                    MS_HDR: begin
                        hdr_q <= hdr_d;
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == MDIO_HDR_LAST) begin
                            cnt_q <= 6'h00;
                            if (hdr_d[12] && hdr_d[9:5] == P_PHY_ADDR &&
                                (hdr_d[11:10] == MDIO_OP_READ ||
                                 hdr_d[11:10] == MDIO_OP_WRITE)) begin
                                st_q <= MS_TA;
                                o_reg_addr <= hdr_d[4:0];
                                is_read_q <= (hdr_d[11:10] == MDIO_OP_READ);
                            end else begin
                                st_q <= MS_PRE;
                            end
                        end
                    end
                    MS_TA: begin
                        cnt_q <= 6'h01;
                        if (cnt_q != 6'h00) begin
                            cnt_q <= 6'h00;
                            if (is_read_q) begin
                                o_mdio_oe <= 1'b1;
                                o_mdio <= 1'b0;
                                sh_q <= i_rd_data;
                                st_q <= MS_RDATA;
                            end else begin
                                st_q <= MS_WDATA;
                            end
                        end
                    end
                    MS_RDATA: begin
                        cnt_q <= cnt_q + 6'h01;
                        o_mdio <= sh_q[15];
                        sh_q <= {sh_q[14:0], 1'b0};
                        if (cnt_q == MDIO_RD_END) begin
                            o_mdio_oe <= 1'b0;
                            o_mdio <= 1'b0;
                            st_q <= MS_PRE;
                            cnt_q <= 6'h00;
                        end
                    end
                    MS_WDATA: begin
                        cnt_q <= cnt_q + 6'h01;
                        sh_q <= {sh_q[14:0], dio_s2_q};
                        if (cnt_q == MDIO_DATA_LAST) begin
                            o_wr_pulse <= 1'b1;
                            o_wr_data <= {sh_q[14:0], dio_s2_q};
                            st_q <= MS_PRE;
                            cnt_q <= 6'h00;
                        end
                    end
                    default: begin
                        st_q <= MS_PRE;
                        cnt_q <= 6'h00;
                    end
                endcase
            end
        end
    end
endmodule

// File: rtl/pcs_config_status.sv
`timescale 1ns/100ps
// Operation
// - Config bit 14 forces the link to be treated as passing; resets zero.
// - Config bit 13 turns the twisted-pair transmitter off.
// - Config bit 12 bypasses scrambler and descrambler at 100 Mb/s twisted pair.
// - Config bit 10 disables jabber correction at 10 Mb/s.
// - Config bit 9 enables heartbeat at 10 Mb/s; resets zero.
// - Config bit 8 stops twisted-pair loopback in 10 Mb/s half duplex.
// - Config bit 7 holds carrier sense until data valid falls at 10 Mb/s; resets one.
// - Config bit 6 enables sleep; reset value taken from sleep pin.
// - Config bit 5 selects data valid at delimiter or at carrier with preamble.
// - Config bits 4:3 pick sleep timeout 3.04, 2.00 or 1.04 s; reset 00.
// - Config bit 2 enables far-end fault transmission; resets one.
// - Config bit 1 enables alternate next-page behaviour; resets zero.
// - Config bit 0 selects fiber; reset value taken from select pin.
// - Status bit 14 reads one at 100 Mb/s over twisted pair.
// - Status bits 13, 12, 11 show transmit, receive and collision activity.
// - Status bit 10 reads one while the link is up.
// - Status bit 9 reads one in full duplex.
// - Status bit 8 reads one in auto-negotiation mode.
// - Status bit 7 shows negotiation complete, equal to basic status bit 5.
// - Status bit 5 reads one when receive polarity is reversed.
// - Status bit 4 reads one when pause capable.
// - Status bit 3 flags errors; bits 15, 6 and 2:0 read zero.
module pcs_config_status import pcs_pkg::*; #(
    parameter logic [4:0] P_PHY_ADDR = 5'h00,
    parameter logic [SLEEP_CNT_W-1:0] P_SLEEP_CYC0 = SLEEP_CYC0,
    parameter logic [SLEEP_CNT_W-1:0] P_SLEEP_CYC1 = SLEEP_CYC1,
    parameter logic [SLEEP_CNT_W-1:0] P_SLEEP_CYC2 = SLEEP_CYC2
) (
    input wire logic i_mclk, // 10 MHz clock.
    input wire logic i_srst, // Synchronous reset, active high.
    input wire logic i_mdc, // Management clock pin.
    input wire logic i_mdio, // Management data pin in.
    output logic o_mdio, // Management data out.
    output logic o_mdio_oe, // Management data drive enable.
    input wire logic i_sleep_pin, // Sleep strap pin.
    input wire logic i_fiber_or_twisted_pair_pin, // Fiber strap pin.
    input wire logic i_speed_100, // Core runs at 100 Mb/s.
    input wire logic i_tx_active, // Core transmits a packet.
    input wire logic i_rx_active, // Core receives a packet.
    input wire logic i_collision, // Collision in progress.
    input wire logic i_link_ok, // Link integrity passes.
    input wire logic i_full_duplex, // Core in full duplex.
    input wire logic i_autoneg_en, // Negotiation mode selected.
    input wire logic i_autoneg_done, // Basic status bit 5.
    input wire logic i_pol_reversed, // Receive polarity reversed.
    input wire logic i_pause_capable, // Pause capable.
    input wire logic i_fault, // Remote fault or other error.
    input wire logic i_crs_raw, // Raw carrier sense.
    input wire logic i_rx_dv, // Receive data valid.
    input wire logic i_energy, // Line energy seen.
    output logic o_link_pass, // Link treated as passing.
    output logic o_tx_disable, // Transmitter off.
    output logic o_scrambler_bypass, // Bypass scrambling.
    output logic o_jabber_disable, // Jabber correction off.
    output logic o_heartbeat_en, // Heartbeat on.
    output logic o_tp_loopback_off, // Loopback suppressed.
    output logic o_crs, // Carrier sense to MAC.
    output logic o_preamble_en, // Data valid from carrier.
    output logic o_sleep, // Sleep state.
    output logic o_fefi_en, // Far-end fault transmit on.
    output logic o_alt_next_page, // Alternate next page.
    output logic o_fiber_mode // Fiber mode selected.
);
    logic slp_s1_q, slp_s2_q, fib_s1_q, fib_s2_q;
    logic strap_done_q;
    logic [15:0] cfg_q;
    logic [15:0] rd_data, status_word;
    logic [4:0] reg_addr;
    logic wr_pulse;
    logic [15:0] wr_data;
    logic [SLEEP_CNT_W-1:0] idle_cnt_q, sleep_limit;
    logic is_10m, tp_100;

    // Assembles the live status word from the core's current state.
    function automatic logic [15:0] pack_status(
        input logic tp100, input logic link, input logic fiber_sel
    );
        logic [15:0] w;
        w = 16'h0000;
        w[14] = tp100 & ~fiber_sel;
        w[13] = i_tx_active;
        w[12] = i_rx_active;
        w[11] = i_collision;
        w[10] = link;
        w[9] = i_full_duplex;
        w[8] = i_autoneg_en;
        w[7] = i_autoneg_done;
        w[5] = i_pol_reversed;
        w[4] = i_pause_capable;
        w[3] = i_fault;
        return w;
    endfunction

    // Selects the idle time before sleep; the undefined code uses the shortest.
    function automatic logic [SLEEP_CNT_W-1:0] sleep_cycles(input logic [1:0] sel);
        case (sel)
            2'h0: return P_SLEEP_CYC0;
            2'h1: return P_SLEEP_CYC1;
            default: return P_SLEEP_CYC2;
        endcase
    endfunction

    pcs_mdio_slave #(
        .P_PHY_ADDR(P_PHY_ADDR)
    ) u_mdio (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_mdc(i_mdc),
        .i_mdio(i_mdio),
        .o_mdio(o_mdio),
        .o_mdio_oe(o_mdio_oe),
        .o_reg_addr(reg_addr),
        .i_rd_data(rd_data),
        .o_wr_pulse(wr_pulse),
        .o_wr_data(wr_data)
    );

    always_ff @(posedge i_mclk) begin
        slp_s1_q <= i_sleep_pin;
        slp_s2_q <= slp_s1_q;
        fib_s1_q <= i_fiber_or_twisted_pair_pin;
        fib_s2_q <= fib_s1_q;
    end

    assign is_10m = ~i_speed_100;
    assign tp_100 = i_speed_100 & ~cfg_q[CFG_FIBER_BIT];
    // The function reads core inputs directly, so it must sit in a process that follows them.
    always_comb begin
        status_word = pack_status(i_speed_100, o_link_pass, cfg_q[CFG_FIBER_BIT]);
    end

    // Status is sampled when the frame needs it and reading alters nothing.
    always_comb begin
        rd_data = 16'h0000;
        if (reg_addr == REG_CONFIG_ADDR) begin
            rd_data = cfg_q & CFG_WR_MASK;
        end else if (reg_addr == REG_STATUS2_ADDR) begin
            rd_data = status_word;
        end
    end

    // Straps are caught on the first edge after reset is released.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            cfg_q <= CFG_RESET_VAL;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            cfg_q[CFG_SLEEP_EN_BIT] <= slp_s2_q;
            cfg_q[CFG_FIBER_BIT] <= fib_s2_q;
        end else if (wr_pulse && reg_addr == REG_CONFIG_ADDR) begin
            cfg_q <= wr_data & CFG_WR_MASK;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_link_pass <= 1'b0;
            o_tx_disable <= 1'b0;
            o_scrambler_bypass <= 1'b0;
            o_fefi_en <= 1'b0;
            o_alt_next_page <= 1'b0;
            o_fiber_mode <= 1'b0;
            o_preamble_en <= 1'b0;
        end else begin
            o_link_pass <= i_link_ok | cfg_q[CFG_FORCE_LINK_BIT];
            o_tx_disable <= cfg_q[CFG_TX_DISABLE_BIT];
            o_scrambler_bypass <= cfg_q[CFG_SCR_BYPASS_BIT] & tp_100;
            o_fefi_en <= cfg_q[CFG_FEFI_EN_BIT];
            o_alt_next_page <= cfg_q[CFG_ALT_NP_BIT];
            o_fiber_mode <= cfg_q[CFG_FIBER_BIT];
            o_preamble_en <= cfg_q[CFG_PREAMBLE_BIT];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_jabber_disable <= 1'b0;
            o_heartbeat_en <= 1'b0;
            o_tp_loopback_off <= 1'b0;
        end else begin
            o_jabber_disable <= cfg_q[CFG_JABBER_OFF_BIT] & is_10m;
            o_heartbeat_en <= cfg_q[CFG_HEARTBEAT_BIT] & is_10m;
            o_tp_loopback_off <= cfg_q[CFG_LOOPBACK_OFF_BIT] & is_10m &
                ~i_full_duplex;
        end
    end

    // At 10 Mb/s with config bit 7 set, carrier is kept up past its own end for as long as data valid lasts.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_crs <= 1'b0;
        end else begin
            o_crs <= i_crs_raw |
                (o_crs & i_rx_dv & cfg_q[CFG_CRS_EXTEND_BIT] & is_10m);
        end
    end

    assign sleep_limit = sleep_cycles(cfg_q[CFG_SLEEP_TMR_HI:CFG_SLEEP_TMR_LO]);

    // Sleep is entered after the chosen idle time without energy or link.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            idle_cnt_q <= '0;
            o_sleep <= 1'b0;
        end else if (!cfg_q[CFG_SLEEP_EN_BIT] || i_energy || o_link_pass) begin
            idle_cnt_q <= '0;
            o_sleep <= 1'b0;
        end else if (idle_cnt_q >= sleep_limit - 1'b1) begin
            o_sleep <= 1'b1;
        end else begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    chk_cfg_reset: assert property ($fell(i_srst) |->
        cfg_q[CFG_CRS_EXTEND_BIT] && cfg_q[CFG_FEFI_EN_BIT] && !cfg_q[CFG_FORCE_LINK_BIT]
        && !cfg_q[CFG_HEARTBEAT_BIT] && cfg_q[4:3] == 2'h0)
        else $error("config reset value wrong");
    chk_strap_capture: assert property ($fell(i_srst) |=>
        cfg_q[CFG_SLEEP_EN_BIT] == $past(slp_s2_q) &&
        cfg_q[CFG_FIBER_BIT] == $past(fib_s2_q))
        else $error("strap not captured");
    chk_cfg_write: assert property (strap_done_q && wr_pulse &&
        reg_addr == REG_CONFIG_ADDR |=> cfg_q == ($past(wr_data) & CFG_WR_MASK)
        ##1 o_tx_disable == cfg_q[CFG_TX_DISABLE_BIT])
        else $error("config write not applied");
    chk_status_ro: assert property (wr_pulse && reg_addr == REG_STATUS2_ADDR
        |=> $stable(cfg_q))
        else $error("status write changed state");
    chk_force_link: assert property (cfg_q[CFG_FORCE_LINK_BIT] ##1
        cfg_q[CFG_FORCE_LINK_BIT] |-> o_link_pass)
        else $error("forced link not passing");
    chk_scr_bypass: assert property (o_scrambler_bypass |->
        $past(i_speed_100) && !$past(cfg_q[CFG_FIBER_BIT]))
        else $error("bypass outside 100 twisted pair");
    chk_ten_only: assert property ((o_jabber_disable || o_heartbeat_en) |->
        !$past(i_speed_100))
        else $error("10 Mb/s option active at 100");
    chk_loopback_hdx: assert property (o_tp_loopback_off |->
        !$past(i_full_duplex) && $past(cfg_q[CFG_LOOPBACK_OFF_BIT]))
        else $error("loopback control wrong");
    chk_crs_hold: assert property (o_crs && i_rx_dv && is_10m &&
        cfg_q[CFG_CRS_EXTEND_BIT] |=> o_crs)
        else $error("carrier dropped before data valid");
    chk_sleep_wake: assert property ((i_energy || !cfg_q[CFG_SLEEP_EN_BIT]) |=>
        !o_sleep)
        else $error("sleep while energy or disabled");
    chk_status_bits: assert property (reg_addr == REG_STATUS2_ADDR |->
        rd_data[15] == 1'b0 && rd_data[6] == 1'b0 && rd_data[2:0] == 3'h0 &&
        rd_data[7] == i_autoneg_done && rd_data[10] == o_link_pass &&
        rd_data[14] == tp_100)
        else $error("status word wrong");

    cov_cfg_write: cover property (wr_pulse && reg_addr == REG_CONFIG_ADDR);
    cov_sleep: cover property ($rose(o_sleep));
    cov_crs_ext: cover property (o_crs && !i_crs_raw);
    cov_status_read: cover property (reg_addr == REG_STATUS2_ADDR && o_mdio_oe);
    cov_force_link: cover property (o_link_pass && !i_link_ok);
endmodule

// File: sim/pcs_mdio_master.sv
`timescale 1ns/100ps
module pcs_mdio_master import pcs_pkg::*; (
    input wire logic i_mclk, // System clock.
    input wire logic i_mdio, // Resolved data line.
    output logic o_mdc, // Management clock, idle low.
    output logic o_mdio, // Data driven by the controller.
    output logic o_mdio_oe // High while driving.
);
    logic ta_bit = 1'h1;
    initial begin
        o_mdc = 1'h0;
        o_mdio = 1'h1;
        o_mdio_oe = 1'h0;
    end
    // One bit period; the line is sampled late in the high phase.
    task automatic tick(input logic oe, input logic b, output logic s);
        o_mdio_oe = oe;
        o_mdio = b;
        repeat (5) @(posedge i_mclk);
        #1 o_mdc = 1'h1;
        repeat (4) @(posedge i_mclk);
        #1 s = i_mdio;
        @(posedge i_mclk);
        #1 o_mdc = 1'h0;
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [45:0] hdr;
        logic s;
        logic wr;
        hdr = {32'hFFFFFFFF, 2'h1, op, phy, ra};
        wr = (op == MDIO_OP_WRITE);
        for (int i = 45; i >= 0; i--) tick(1'h1, hdr[i], s);
        tick(wr, 1'h1, s);
        tick(wr, 1'h0, ta_bit);
        for (int i = 15; i >= 0; i--) begin
            tick(wr, wd[i], s);
            rd[i] = s;
        end
        tick(1'h0, 1'h1, s);
    endtask
endmodule

// File: sim/pcs_config_status_tb.sv
`timescale 1ns/100ps
module pcs_config_status_tb import pcs_pkg::*;;
    localparam int C0 = 40;
    localparam int C1 = 30;
    localparam int C2 = 20;
    logic clk = 1'h0, srst = 1'h1, sleep_pin = 1'h0, fib_pin = 1'h0;
    logic crs_raw = 1'h0, rx_dv = 1'h0, energy = 1'h1;
    logic [10:0] st_in = 11'h000;
    logic [15:0] rd;
    logic mdc, m_out, m_oe, d_out, d_oe, crs, slp;
    logic [9:0] outs;
    int mismatches = 0;
    int comparisons = 0;
    // The data line has a pull-up, so a released line reads one.
    wire mdio_w = d_oe ? d_out : (m_oe ? m_out : 1'h1);
    always #50 clk = ~clk;
    pcs_mdio_master u_mst (.i_mclk(clk), .i_mdio(mdio_w), .o_mdc(mdc), .o_mdio(m_out),
        .o_mdio_oe(m_oe));
    pcs_config_status #(.P_SLEEP_CYC0(SLEEP_CNT_W'(C0)), .P_SLEEP_CYC1(SLEEP_CNT_W'(C1)),
        .P_SLEEP_CYC2(SLEEP_CNT_W'(C2))) u_dut (
        .i_mclk(clk), .i_srst(srst), .i_mdc(mdc), .i_mdio(mdio_w), .o_mdio(d_out),
        .o_mdio_oe(d_oe), .i_sleep_pin(sleep_pin), .i_fiber_or_twisted_pair_pin(fib_pin),
        .i_speed_100(st_in[10]), .i_tx_active(st_in[9]), .i_rx_active(st_in[8]),
        .i_collision(st_in[7]), .i_link_ok(st_in[6]), .i_full_duplex(st_in[5]),
        .i_autoneg_en(st_in[4]), .i_autoneg_done(st_in[3]), .i_pol_reversed(st_in[2]),
        .i_pause_capable(st_in[1]), .i_fault(st_in[0]), .i_crs_raw(crs_raw),
        .i_rx_dv(rx_dv), .i_energy(energy), .o_link_pass(outs[9]), .o_tx_disable(outs[8]),
        .o_scrambler_bypass(outs[7]), .o_jabber_disable(outs[6]), .o_heartbeat_en(outs[5]),
        .o_tp_loopback_off(outs[4]), .o_crs(crs), .o_preamble_en(outs[3]), .o_sleep(slp),
        .o_fefi_en(outs[2]), .o_alt_next_page(outs[1]), .o_fiber_mode(outs[0]));
    function automatic logic [15:0] exp_out(logic [15:0] c, logic sp, logic fd, logic lk);
        return {6'h00, lk | c[14], c[13], c[12] & sp & ~c[0], c[10] & ~sp, c[9] & ~sp,
            c[8] & ~sp & ~fd, c[5], c[2], c[1], c[0]};
    endfunction
    function automatic logic [15:0] exp_st(logic [10:0] s, logic [15:0] c);
        return {1'h0, s[10] & ~c[0], s[9:7], s[6] | c[14], s[5:3], 1'h0, s[2:0], 3'h0};
    endfunction
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("ERROR %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic rd_reg(input logic [4:0] a);
        u_mst.frame(MDIO_OP_READ, 5'h00, a, 16'h0000, rd);
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] unused;
        u_mst.frame(MDIO_OP_WRITE, 5'h00, a, d, unused);
    endtask
    task automatic do_reset(input logic sp, input logic fp);
        srst = 1'h1;
        sleep_pin = sp;
        fib_pin = fp;
        repeat (10) @(posedge clk);
        #1 srst = 1'h0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic t_reset();
        do_reset(1'h0, 1'h0);
        rd_reg(REG_CONFIG_ADDR);
        chk(rd, 16'h0084);
        chk(u_mst.ta_bit, 16'h0000);
        chk({6'h00, outs}, exp_out(16'h0084, 1'h0, 1'h0, 1'h0));
        do_reset(1'h1, 1'h1);
        rd_reg(REG_CONFIG_ADDR);
        chk(rd, 16'h00C5);
        chk({6'h00, outs}, exp_out(16'h00C5, 1'h0, 1'h0, 1'h0));
    endtask
    task automatic t_config();
        logic [15:0] c;
        logic [15:0] tbl [5] = '{16'hFFFF, 16'h0000, 16'h5A5A, 16'h2525, 16'h7FFE};
        foreach (tbl[n]) begin
            c = tbl[n] & CFG_WR_MASK;
            wr_reg(REG_CONFIG_ADDR, tbl[n]);
            rd_reg(REG_CONFIG_ADDR);
            chk(rd, c);
            for (int k = 0; k < 4; k++) begin
                {st_in[10], st_in[5]} = 2'(k);
                repeat (2) @(posedge clk);
                #1 chk({6'h00, outs}, exp_out(c, st_in[10], st_in[5], 1'h0));
            end
        end
    endtask
    task automatic t_status();
        wr_reg(REG_CONFIG_ADDR, 16'h0084);
        for (int i = 0; i < 11; i++) begin
            st_in = 11'h001 << i;
            rd_reg(REG_STATUS2_ADDR);
            chk(rd, exp_st(st_in, 16'h0084));
        end
        st_in = 11'h7FF;
        wr_reg(REG_STATUS2_ADDR, 16'hFFFF);
        rd_reg(REG_STATUS2_ADDR);
        chk(rd, exp_st(st_in, 16'h0084));
        rd_reg(REG_CONFIG_ADDR);
        chk(rd, 16'h0084);
        wr_reg(REG_CONFIG_ADDR, 16'h4001);
        st_in = 11'h400;
        rd_reg(REG_STATUS2_ADDR);
        chk(rd, exp_st(st_in, 16'h4001));
        rd_reg(5'h12);
        chk(rd, 16'h0000);
        u_mst.frame(MDIO_OP_READ, 5'h01, REG_CONFIG_ADDR, 16'h0000, rd);
        chk(rd, 16'hFFFF);
    endtask
    task automatic t_crs(input logic [15:0] c, input logic held);
        wr_reg(REG_CONFIG_ADDR, c);
        st_in = 11'h000;
        crs_raw = 1'h1;
        rx_dv = 1'h1;
        repeat (2) @(posedge clk);
        #1 crs_raw = 1'h0;
        repeat (5) @(posedge clk);
        #1 chk({15'h0000, crs}, {15'h0000, held});
        rx_dv = 1'h0;
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, crs}, 16'h0000);
    endtask
    task automatic t_sleep(input logic [1:0] code, input int lim);
        int n;
        do_reset(1'h1, 1'h0);
        wr_reg(REG_CONFIG_ADDR, 16'h00C4 | (16'(code) << 3));
        energy = 1'h0;
        n = 0;
        while (slp !== 1'h1 && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 200) begin
            mismatches++;
            summarize();
        end
        chk_rng(n, lim - 2, lim + 4);
        energy = 1'h1;
    endtask
    initial begin
        t_reset();
        t_config();
        t_status();
        t_crs(16'h0084, 1'h1);
        t_crs(16'h0004, 1'h0);
        t_sleep(2'h0, C0);
        t_sleep(2'h1, C1);
        t_sleep(2'h2, C2);
        t_sleep(2'h3, C2);
        do_reset(1'h0, 1'h0);
        energy = 1'h0;
        repeat (100) @(posedge clk);
        #1 chk({15'h0000, slp}, 16'h0000);
        summarize();
    end
endmodule
